// >>> core/pdst_top.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pdst_top #(
	parameter int STRAP_W = pdst_pkg::PDST_STRAP_W
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Control pins
	input  wire logic               chip_enable_n,
	input  wire logic               self_test_enable_pin,
	input  wire logic               shared_pin_in,
	input  wire logic [STRAP_W-1:0] config_strap_0,
	input  wire logic [STRAP_W-1:0] config_strap_1,
	// Shared pin drive
	output logic                    shared_pin_o,
	output logic                    shared_pin_oe,
	// Fast gpio 3 / peripheral select
	input  wire logic               fast_gpio_3_o_core,
	input  wire logic               fast_gpio_3_oe_core,
	input  wire logic               spi_select_core,
	output logic                    fast_gpio_3_o,
	output logic                    fast_gpio_3_oe,
	// Core status
	output logic                    powered_up,
	output logic                    core_reset,
	output logic                    pll_enable,
	output logic                    cmos_out_enable,
	output logic                    self_test_active,
	output logic                    self_test_clk_fixed,
	output logic                    interrupt_active,
	// Register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic [31:0]             reg_rdata
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// True when a bus address selects the given register.
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		addr_hit = (addr == target);
	endfunction : addr_hit

	// True when the power state machine sits in the given state.
	function automatic logic in_state(
		input pdst_pkg::pdst_state_e current,
		input pdst_pkg::pdst_state_e wanted
	);
		in_state = (current == wanted);
	endfunction : in_state

	// ----------------------------------------
	// Power state
	// ----------------------------------------
	pdst_pkg::pdst_state_e state_reg;
	logic                  enabled;
	logic                  soft_rst;
	assign enabled  = chip_enable_n;
	// Every state but normal operation holds the core in reset, so a
	// bring-up always passes through one full cycle of reset first.
	assign soft_rst = !in_state(state_reg, pdst_pkg::PDST_ST_RUN);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= pdst_pkg::PDST_ST_DOWN; // [R2]
		end else begin
			case (state_reg)
				pdst_pkg::PDST_ST_DOWN: begin
					if (enabled) state_reg <= pdst_pkg::PDST_ST_RESET; // [R1]
				end
				pdst_pkg::PDST_ST_RESET: begin
					state_reg <= enabled ? pdst_pkg::PDST_ST_RUN : pdst_pkg::PDST_ST_DOWN;
				end
				pdst_pkg::PDST_ST_RUN: begin
					if (!enabled) state_reg <= pdst_pkg::PDST_ST_DOWN; // [R2]
				end
				default: state_reg <= pdst_pkg::PDST_ST_DOWN;
			endcase
		end
	end

	// ----------------------------------------
	// Control register, cleared on bring-up
	// ----------------------------------------
	logic [2:0] ctrl_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= pdst_pkg::PDST_CTRL_RESET;
		end else if (soft_rst) begin
			ctrl_reg <= pdst_pkg::PDST_CTRL_RESET; // [R1]
		end else if (reg_write && addr_hit(reg_addr, pdst_pkg::PDST_ADDR_CTRL)) begin
			ctrl_reg <= reg_wdata[2:0];
		end
	end

	// ----------------------------------------
	// Strap capture at enable release
	// ----------------------------------------
	logic [STRAP_W-1:0] strap0_reg;
	logic [STRAP_W-1:0] strap1_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap0_reg <= '0;
			strap1_reg <= '0;
		end else if (in_state(state_reg, pdst_pkg::PDST_ST_DOWN) && enabled) begin
			strap0_reg <= config_strap_0; // [R9]
			strap1_reg <= config_strap_1; // [R9]
		end
	end

	// ----------------------------------------
	// Pin functions
	// ----------------------------------------
	logic clksel_mode;
	logic spisel_mode;
	logic run;
	assign clksel_mode = ctrl_reg[pdst_pkg::PDST_CTRL_CLKSEL_BIT];
	assign spisel_mode = ctrl_reg[pdst_pkg::PDST_CTRL_SPISEL_BIT];
	assign run         = in_state(state_reg, pdst_pkg::PDST_ST_RUN);

	pdst_pkg::pdst_pin_s gpio3_next;
	always_comb begin
		gpio3_next = '0; // [R3]
		if (run) begin
			if (spisel_mode) begin
				gpio3_next.o  = spi_select_core; // [R8]
				gpio3_next.oe = 1'b1;
			end else begin
				gpio3_next.o  = fast_gpio_3_o_core;
				gpio3_next.oe = fast_gpio_3_oe_core;
			end
		end
	end

	// ----------------------------------------
	// Power-state outputs
	// ----------------------------------------
	// Each output has its own register, so all of them follow the state
	// machine by exactly one cycle and none can glitch.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			powered_up <= 1'b0;
		end else begin
			powered_up <= run;
		end
	end

	// The core is held in reset in every state but normal operation.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			core_reset <= 1'b1;
		end else begin
			core_reset <= soft_rst; // [R1]
		end
	end

	// The loop is stopped whenever the device is not running.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pll_enable <= 1'b0;
		end else begin
			pll_enable <= run; // [R3]
		end
	end

	// Single-ended outputs float while the device is powered down.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmos_out_enable <= 1'b0;
		end else begin
			cmos_out_enable <= run; // [R3]
		end
	end

	// ----------------------------------------
	// Self-test
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			self_test_active <= 1'b0;
		end else begin
			self_test_active <= run && self_test_enable_pin; // [R5]
		end
	end

	// The fixed source is chosen only while the shared pin is in clock-select mode.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			self_test_clk_fixed <= pdst_pkg::PDST_CLK_PIXEL;
		end else begin
			self_test_clk_fixed <= (run && clksel_mode && shared_pin_in)
				? pdst_pkg::PDST_CLK_FIXED : pdst_pkg::PDST_CLK_PIXEL; // [R6]
		end
	end

	// ----------------------------------------
	// Shared pin
	// ----------------------------------------
	// The pin is an active-low interrupt unless software picked clock select.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			interrupt_active <= 1'b0;
		end else begin
			interrupt_active <= run && !clksel_mode && !shared_pin_in; // [R7]
		end
	end

	// The pin is only ever driven low, never high.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shared_pin_o <= 1'b0;
		end else begin
			shared_pin_o <= 1'b0;
		end
	end

	// While not running the pin is pulled low once the DRVINT bit is clear; ctrl_reg is cleared then.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shared_pin_oe <= 1'b0;
		end else begin
			shared_pin_oe <= !run && ctrl_reg[pdst_pkg::PDST_CTRL_DRVINT_BIT] == 1'b0; // [R7]
		end
	end

	// ----------------------------------------
	// Fast gpio 3 drive
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fast_gpio_3_o <= 1'b0;
		end else begin
			fast_gpio_3_o <= gpio3_next.o; // [R8]
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fast_gpio_3_oe <= 1'b0;
		end else begin
			fast_gpio_3_oe <= gpio3_next.oe; // [R3]
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	logic [31:0] status_word;
	logic [31:0] rdata_next;
	assign status_word = {27'h0, interrupt_active, self_test_clk_fixed, self_test_active, state_reg};

	// Read data stand for one cycle after the strobe and are zero otherwise.
	always_comb begin
		rdata_next = '0;
		if (reg_read) begin
			case (reg_addr)
				pdst_pkg::PDST_ADDR_CTRL:   rdata_next = {29'h0, ctrl_reg};
				pdst_pkg::PDST_ADDR_STATUS: rdata_next = status_word;
				pdst_pkg::PDST_ADDR_STRAPS: rdata_next = 32'({strap1_reg, strap0_reg});
				default:                    rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rdata_next;
		end
	end

endmodule : pdst_top
`default_nettype wire

// >>> core/pdst_pkg.sv
// Contract
// R1: Enable high resets state, starts normal operation.
// R2: Enable low keeps device powered down.
// R3: Powered down: CMOS outputs tristated, PLL off.
// R4: Host holds enable low until supplies good.
// R5: Self-test pin: 0 disables, 1 enables.
// R6: Clock select: 0 pixel clock, 1 33 MHz.
// R7: Shared pin defaults interrupt; may pull low.
// R8: Peripheral select on GPIO3 only by register.
// R9: Straps latched at enable release, held until powerdown.
package pdst_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] PDST_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] PDST_ADDR_STATUS = 8'h04;
	localparam logic [7:0] PDST_ADDR_STRAPS = 8'h08;

	localparam int PDST_CTRL_CLKSEL_BIT = 0;
	localparam int PDST_CTRL_SPISEL_BIT = 1;
	localparam int PDST_CTRL_DRVINT_BIT = 2;
	localparam logic [2:0] PDST_CTRL_RESET = 3'h0;

	localparam int PDST_STRAP_W = 4;

	// ----------------------------------------
	// Clock choices for self-test
	// ----------------------------------------
	localparam logic PDST_CLK_PIXEL = 1'h0;
	localparam logic PDST_CLK_FIXED = 1'h1;
	localparam int   PDST_FIXED_CLK_MHZ = 33;

	typedef enum logic [1:0] {
		PDST_ST_DOWN  = 2'b00,
		PDST_ST_RESET = 2'b01,
		PDST_ST_RUN   = 2'b10
	} pdst_state_e;

	typedef struct packed {
		logic o;
		logic oe;
	} pdst_pin_s;

endpackage : pdst_pkg

// >>> dv/pdst_props.sv
`timescale 1ns/1ps
`default_nettype none
module pdst_props (
	// Watched ports
	input wire logic clock,
	input wire logic resetn,
	input wire logic chip_enable_n,
	input wire logic self_test_enable_pin,
	input wire logic shared_pin_o,
	input wire logic shared_pin_oe,
	input wire logic fast_gpio_3_oe,
	input wire logic powered_up,
	input wire logic core_reset,
	input wire logic pll_enable,
	input wire logic cmos_out_enable,
	input wire logic self_test_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_up; $rose(chip_enable_n) ##1 chip_enable_n[*2] |=> powered_up; endproperty
	a_up: assert property (p_up) else $error("no power up");
	property p_rst; core_reset != powered_up; endproperty
	a_rst: assert property (p_rst) else $error("core reset wrong");
	property p_down; !chip_enable_n[*2] |=> !powered_up; endproperty
	a_down: assert property (p_down) else $error("not powered down");
	property p_off; !powered_up |-> !pll_enable && !cmos_out_enable; endproperty
	a_off: assert property (p_off) else $error("pll or outputs on");
	property p_gpio; !chip_enable_n[*3] |=> !fast_gpio_3_oe; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio driven while down");
	property p_drv; !chip_enable_n[*3] |=> shared_pin_oe && !shared_pin_o; endproperty
	a_drv: assert property (p_drv) else $error("shared pin not pulled low");
	property p_st_on; (powered_up && self_test_enable_pin)[*2] |-> self_test_active; endproperty
	a_st_on: assert property (p_st_on) else $error("self test not on");
	property p_st_off; !self_test_enable_pin[*2] |-> !self_test_active; endproperty
	a_st_off: assert property (p_st_off) else $error("self test not off");
endmodule : pdst_props
bind pdst_top pdst_props i_pdst_props (.clock, .resetn, .chip_enable_n, .self_test_enable_pin, .shared_pin_o,
	.shared_pin_oe, .fast_gpio_3_oe, .powered_up, .core_reset, .pll_enable, .cmos_out_enable, .self_test_active);
`default_nettype wire

// >>> dv/pdst_host.sv
`timescale 1ns/1ps
`default_nettype none
module pdst_host (
	// Host side
	input  wire logic clock,
	input  wire logic supplies_ok,
	input  wire logic want_on,
	// Pin
	output logic      chip_enable_n
);
	initial chip_enable_n = 1'h0;
	always @(posedge clock) chip_enable_n <= want_on & supplies_ok;
endmodule : pdst_host
`default_nettype wire

// >>> dv/test_pdst_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_pdst_top;
	logic clock, resetn, chip_enable_n, self_test_enable_pin, shared_pin_in, shared_pin_o, shared_pin_oe;
	logic fast_gpio_3_o_core, fast_gpio_3_oe_core, spi_select_core, fast_gpio_3_o, fast_gpio_3_oe, powered_up;
	logic core_reset, pll_enable, cmos_out_enable, self_test_active, self_test_clk_fixed, interrupt_active;
	logic reg_write, reg_read, supplies_ok, want_on;
	logic [3:0] config_strap_0, config_strap_1;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [39:0] rows [4] = '{40'h00_00000000, 40'h08_0000005E, 40'h04_00000002, 40'h0C_00000000};
	int fail_count, comparisons, cycles;
	pdst_host i_pdst_host (.clock, .supplies_ok, .want_on, .chip_enable_n);
	pdst_top i_pdst_top (.clock, .resetn, .chip_enable_n, .self_test_enable_pin, .shared_pin_in, .config_strap_0,
		.config_strap_1, .shared_pin_o, .shared_pin_oe, .fast_gpio_3_o_core, .fast_gpio_3_oe_core, .spi_select_core,
		.fast_gpio_3_o, .fast_gpio_3_oe, .powered_up, .core_reset, .pll_enable, .cmos_out_enable, .self_test_active,
		.self_test_clk_fixed, .interrupt_active, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
	task report_and_stop;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clock);
		reg_write <= 1'h0;
		repeat (3) @(posedge clock);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clock);
		reg_read <= 1'h0;
		@(posedge clock);
		chk("rdata", e, reg_rdata);
	endtask : rd
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			report_and_stop;
		end
	end
	initial begin
		{resetn, self_test_enable_pin, fast_gpio_3_o_core, spi_select_core, reg_write, reg_read} = 6'h00;
		{supplies_ok, want_on, reg_addr, reg_wdata} = 42'h0;
		{shared_pin_in, fast_gpio_3_oe_core, config_strap_0, config_strap_1} = 10'h3E5;
		repeat (5) @(posedge clock);
		resetn <= 1'h1;
		want_on <= 1'h1;
		repeat (6) @(posedge clock);
		chk("held down", 0, powered_up);
		supplies_ok <= 1'h1;
		repeat (5) @(posedge clock);
		config_strap_0 <= 4'h3;
		foreach (rows[i]) rd(rows[i][39:32], rows[i][31:0]);
		shared_pin_in <= 1'h0;
		repeat (3) @(posedge clock);
		chk("irq", 1, interrupt_active);
		self_test_enable_pin <= 1'h1;
		shared_pin_in <= 1'h1;
		wr(8'h00, 32'h1);
		chk("fixed", 1, self_test_clk_fixed);
		chk("self test", 1, self_test_active);
		shared_pin_in <= 1'h0;
		repeat (3) @(posedge clock);
		chk("pixel", 0, self_test_clk_fixed);
		chk("irq off", 0, interrupt_active);
		spi_select_core <= 1'h1;
		wr(8'h00, 32'h2);
		chk("spi", 1, fast_gpio_3_o);
		wr(8'h00, 32'h0);
		chk("gpio", 0, fast_gpio_3_o);
		want_on <= 1'h0;
		repeat (5) @(posedge clock);
		chk("pll", 0, pll_enable);
		chk("pull", 1, shared_pin_oe);
		chk("cmos", 0, cmos_out_enable);
		chk("core reset", 1, core_reset);
		chk("gpio oe", 0, fast_gpio_3_oe);
		want_on <= 1'h1;
		repeat (6) @(posedge clock);
		rd(8'h08, 32'h53);
		report_and_stop;
	end
endmodule : test_pdst_top
`default_nettype wire
